// [ccsr_core_regs.sv]
// Contract
// RULE1 - Carry follows last arithmetic carry or borrow
// RULE2 - Half-carry follows nibble carry or borrow
// RULE3 - Two user flags, software only
// RULE4 - Bank bits pick base 0x00/08/10/18
// RULE5 - Parity bit tracks odd accumulator ones
// RULE6 - Status word resets zero, parity read-only
// RULE7 - Address 0xD0 selects status word
// RULE8 - Address 0xE0 selects accumulator, resets zero
// RULE9 - Address 0xF0 selects second accumulator
// RULE10 - Address 0x81 selects stack pointer
// RULE11 - Addresses 0x82/0x83 select pointer bytes
// RULE12 - Software avoids unassigned addresses
// RULE13 - Software writes zero to reserved bits
// RULE14 - Stack pointer resets to 0x07
// RULE15 - Push increments pointer, then writes there
// RULE16 - Only x0/x8 registers are bit-addressable
// RULE17 - Pointer bytes form sixteen bits, reset zero
`timescale 1ns/1ps
`default_nettype none
module ccsr_core_regs (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire ccsr_pkg::ccsr_sfr_req_type i_sfr_req,
	input wire ccsr_pkg::ccsr_bit_req_type i_bit_req,
	input wire ccsr_pkg::ccsr_alu_flags_type i_alu_flags,
	input wire logic i_acc_load,
	input wire logic [7:0] i_acc_value,
	input wire logic i_b_load,
	input wire logic [7:0] i_b_value,
	input wire logic i_dptr_load,
	input wire logic [15:0] i_dptr_value,
	input wire logic i_push,
	input wire logic i_pop,
	output logic [7:0] o_sfr_rdata,
	output logic o_sfr_hit,
	output logic o_bit_rdata,
	output logic o_bit_hit,
	output logic [7:0] o_psw,
	output logic [7:0] o_acc,
	output logic [7:0] o_b,
	output logic [7:0] o_sp,
	output logic [15:0] o_dptr,
	output logic [7:0] o_bank_base,
	output logic o_stack_wr,
	output logic o_stack_rd,
	output logic [7:0] o_stack_addr
);
	logic sel_sp;
	logic sel_dpl;
	logic sel_dph;
	logic sel_psw;
	logic sel_acc;
	logic sel_b;
	logic bsel_psw;
	logic bsel_acc;
	logic bsel_b;
	logic [7:0] bit_byte;
	logic [2:0] bit_idx;
	logic [6:0] psw_hi;
	logic parity;
	logic [7:0] acc_next;
	logic [7:0] next_sp;
	logic sp_hw_we;
	logic [7:0] psw_full;
	logic [7:0] dpl_q;
	logic [7:0] dph_q;

	// Byte decode
	always_comb begin
		sel_sp = 1'b0;
		sel_dpl = 1'b0;
		sel_dph = 1'b0;
		sel_psw = 1'b0;
		sel_acc = 1'b0;
		sel_b = 1'b0;
		if (i_sfr_req.addr == ccsr_pkg::ADDR_PSW) begin
			sel_psw = 1'b1; // RULE7
		end else if (i_sfr_req.addr == ccsr_pkg::ADDR_ACC) begin
			sel_acc = 1'b1; // RULE8
		end else if (i_sfr_req.addr == ccsr_pkg::ADDR_B) begin
			sel_b = 1'b1; // RULE9
		end else if (i_sfr_req.addr == ccsr_pkg::ADDR_SP) begin
			sel_sp = 1'b1; // RULE10
		end else if (i_sfr_req.addr == ccsr_pkg::ADDR_DPL) begin
			sel_dpl = 1'b1; // RULE11
		end else if (i_sfr_req.addr == ccsr_pkg::ADDR_DPH) begin
			sel_dph = 1'b1; // RULE11
		end
	end

	// A bit address always names a byte ending in x0 or x8, so byte-only registers are unreachable here
	assign bit_byte = {i_bit_req.addr[7:3], ccsr_pkg::BIT_BYTE_LOW}; // RULE16
	assign bit_idx = i_bit_req.addr[2:0];

	always_comb begin
		bsel_psw = 1'b0;
		bsel_acc = 1'b0;
		bsel_b = 1'b0;
		if (bit_byte == ccsr_pkg::ADDR_PSW) begin
			bsel_psw = 1'b1; // RULE16
		end else if (bit_byte == ccsr_pkg::ADDR_ACC) begin
			bsel_acc = 1'b1; // RULE16
		end else if (bit_byte == ccsr_pkg::ADDR_B) begin
			bsel_b = 1'b1; // RULE16
		end
	end

	ccsr_sfr_reg #(.RESET_VALUE(ccsr_pkg::RST_ZERO)) u_acc (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_byte_we(i_sfr_req.wr && sel_acc), // RULE8
		.i_byte_data(i_sfr_req.wdata),
		.i_bit_we(i_bit_req.wr && bsel_acc),
		.i_bit_idx(bit_idx),
		.i_bit_data(i_bit_req.wdata),
		.i_hw_we(i_acc_load),
		.i_hw_data(i_acc_value),
		.o_next(acc_next),
		.o_q(o_acc)
	);

	ccsr_sfr_reg #(.RESET_VALUE(ccsr_pkg::RST_ZERO)) u_b (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_byte_we(i_sfr_req.wr && sel_b), // RULE9
		.i_byte_data(i_sfr_req.wdata),
		.i_bit_we(i_bit_req.wr && bsel_b),
		.i_bit_idx(bit_idx),
		.i_bit_data(i_bit_req.wdata),
		.i_hw_we(i_b_load),
		.i_hw_data(i_b_value),
		.o_next(),
		.o_q(o_b)
	);

	// Push and pop together cancel out, leaving the pointer unchanged
	always_comb begin
		sp_hw_we = i_push ^ i_pop;
		next_sp = o_sp;
		if (i_push && !i_pop) begin
			next_sp = o_sp + ccsr_pkg::STACK_STEP; // RULE15
		end else if (i_pop && !i_push) begin
			next_sp = o_sp - ccsr_pkg::STACK_STEP;
		end
	end

	ccsr_sfr_reg #(.RESET_VALUE(ccsr_pkg::RST_SP)) u_sp ( // RULE14
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_byte_we(i_sfr_req.wr && sel_sp), // RULE10
		.i_byte_data(i_sfr_req.wdata),
		.i_bit_we(1'b0),
		.i_bit_idx(bit_idx),
		.i_bit_data(i_bit_req.wdata),
		.i_hw_we(sp_hw_we),
		.i_hw_data(next_sp),
		.o_next(),
		.o_q(o_sp)
	);

	ccsr_sfr_reg #(.RESET_VALUE(ccsr_pkg::RST_ZERO)) u_dpl ( // RULE17
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_byte_we(i_sfr_req.wr && sel_dpl), // RULE11
		.i_byte_data(i_sfr_req.wdata),
		.i_bit_we(1'b0),
		.i_bit_idx(bit_idx),
		.i_bit_data(i_bit_req.wdata),
		.i_hw_we(i_dptr_load),
		.i_hw_data(i_dptr_value[7:0]),
		.o_next(),
		.o_q(dpl_q)
	);

	ccsr_sfr_reg #(.RESET_VALUE(ccsr_pkg::RST_ZERO)) u_dph ( // RULE17
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_byte_we(i_sfr_req.wr && sel_dph), // RULE11
		.i_byte_data(i_sfr_req.wdata),
		.i_bit_we(1'b0),
		.i_bit_idx(bit_idx),
		.i_bit_data(i_bit_req.wdata),
		.i_hw_we(i_dptr_load),
		.i_hw_data(i_dptr_value[15:8]),
		.o_next(),
		.o_q(dph_q)
	);

	// Upper seven status bits; parity has its own flop and ignores writes
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			psw_hi <= ccsr_pkg::RST_PSW_HI; // RULE6
		end else begin
			if (i_sfr_req.wr && sel_psw) begin
				psw_hi <= i_sfr_req.wdata[7:1]; // RULE6
			end else if (i_bit_req.wr && bsel_psw && (bit_idx != ccsr_pkg::PSW_PARITY)) begin
				psw_hi[bit_idx - 3'h1] <= i_bit_req.wdata; // RULE3
			end
			// The flag result of an instruction overrides a same-cycle software write
			if (i_alu_flags.valid) begin
				psw_hi[ccsr_pkg::PSW_CY - 3'h1] <= i_alu_flags.carry; // RULE1
				psw_hi[ccsr_pkg::PSW_AC - 3'h1] <= i_alu_flags.half_carry; // RULE2
			end
		end
	end

	// Parity is taken from the accumulator's next value so it never lags a load
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			parity <= ccsr_pkg::RST_PARITY;
		end else begin
			parity <= ^acc_next; // RULE5
		end
	end

	assign psw_full = {psw_hi, parity};
	assign o_psw = psw_full;
	assign o_dptr = {dph_q, dpl_q}; // RULE17
	assign o_bank_base = {3'h0, psw_hi[ccsr_pkg::PSW_RS1 - 3'h1], psw_hi[ccsr_pkg::PSW_RS0 - 3'h1], 3'h0}; // RULE4

	// Stack memory strobe: the write goes to the already incremented location
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_stack_wr <= 1'b0;
			o_stack_rd <= 1'b0;
			o_stack_addr <= ccsr_pkg::RST_SP;
		end else begin
			o_stack_wr <= i_push && !i_pop;
			o_stack_rd <= i_pop && !i_push;
			if (i_push && !i_pop) begin
				o_stack_addr <= next_sp; // RULE15
			end else if (i_pop && !i_push) begin
				o_stack_addr <= o_sp;
			end
		end
	end

	// Reads show the value before any write of the same cycle; unassigned addresses read zero
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sfr_rdata <= ccsr_pkg::READ_UNMAPPED;
			o_sfr_hit <= 1'b0;
		end else if (i_sfr_req.rd) begin
			o_sfr_hit <= 1'b1;
			if (sel_psw) begin
				o_sfr_rdata <= psw_full;
			end else if (sel_acc) begin
				o_sfr_rdata <= o_acc;
			end else if (sel_b) begin
				o_sfr_rdata <= o_b;
			end else if (sel_sp) begin
				o_sfr_rdata <= o_sp;
			end else if (sel_dpl) begin
				o_sfr_rdata <= o_dptr[7:0];
			end else if (sel_dph) begin
				o_sfr_rdata <= o_dptr[15:8];
			end else begin
				o_sfr_rdata <= ccsr_pkg::READ_UNMAPPED; // RULE12
				o_sfr_hit <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bit_rdata <= 1'b0;
			o_bit_hit <= 1'b0;
		end else if (i_bit_req.rd) begin
			o_bit_hit <= bsel_psw || bsel_acc || bsel_b;
			if (bsel_psw) begin
				o_bit_rdata <= psw_full[bit_idx];
			end else if (bsel_acc) begin
				o_bit_rdata <= o_acc[bit_idx];
			end else if (bsel_b) begin
				o_bit_rdata <= o_b[bit_idx];
			end else begin
				o_bit_rdata <= 1'b0;
			end
		end
	end
endmodule : ccsr_core_regs
`default_nettype wire

// [ccsr_core_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module ccsr_core_regs_sva (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire ccsr_pkg::ccsr_sfr_req_type i_sfr_req,
	input wire ccsr_pkg::ccsr_bit_req_type i_bit_req,
	input wire ccsr_pkg::ccsr_alu_flags_type i_alu_flags,
	input wire logic i_acc_load,
	input wire logic i_b_load,
	input wire logic i_dptr_load,
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_sfr_hit,
	input wire logic o_bit_rdata,
	input wire logic o_bit_hit,
	input wire logic [7:0] o_psw,
	input wire logic [7:0] o_acc,
	input wire logic [7:0] o_b,
	input wire logic [7:0] o_sp,
	input wire logic [15:0] o_dptr,
	input wire logic [7:0] o_bank_base,
	input wire logic o_stack_wr,
	input wire logic [7:0] o_stack_addr
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	logic sw_psw;
	logic acc_bit;
	logic [7:0] a;
	assign a = i_sfr_req.addr;
	// Any software path into the status word may legally move the user bits
	assign sw_psw = (i_sfr_req.wr && a == ccsr_pkg::ADDR_PSW) || (i_bit_req.wr && i_bit_req.addr[7:3] == 5'h1A);
	assign acc_bit = o_acc[i_bit_req.addr[2:0]];
	parity_odd_a: assert property (o_psw[0] == ^o_acc)
		else $error("parity bit wrong");
	bank_map_a: assert property (o_bank_base == 8'(o_psw[4:3]) * 8'h08)
		else $error("bank base wrong");
	acc_write_a: assert property (i_sfr_req.wr && a == ccsr_pkg::ADDR_ACC && !i_acc_load |=>
		o_acc == $past(i_sfr_req.wdata)) else $error("accumulator write lost");
	b_write_a: assert property (i_sfr_req.wr && a == ccsr_pkg::ADDR_B && !i_b_load |=>
		o_b == $past(i_sfr_req.wdata)) else $error("second accumulator write lost");
	dph_write_a: assert property (i_sfr_req.wr && a == ccsr_pkg::ADDR_DPH && !i_dptr_load |=>
		o_dptr[15:8] == $past(i_sfr_req.wdata)) else $error("pointer high byte wrong");
	alu_flags_a: assert property (i_alu_flags.valid |=>
		o_psw[7:6] == {$past(i_alu_flags.carry), $past(i_alu_flags.half_carry)}) else $error("flags not loaded");
	user_bits_a: assert property (!sw_psw |=> $stable(o_psw[5:1]))
		else $error("software bits changed by hardware");
	push_step_a: assert property (i_push && !i_pop |=>
		o_stack_wr && o_sp == $past(o_sp) + 8'h01 && o_stack_addr == o_sp) else $error("push step wrong");
	sp_read_a: assert property (i_sfr_req.rd && a == ccsr_pkg::ADDR_SP |=>
		o_sfr_hit && o_sfr_rdata == $past(o_sp)) else $error("stack pointer read wrong");
	psw_read_a: assert property (i_sfr_req.rd && a == ccsr_pkg::ADDR_PSW |=>
		o_sfr_hit && o_sfr_rdata == $past(o_psw)) else $error("status read wrong");
	acc_bit_a: assert property (i_bit_req.rd && i_bit_req.addr[7:3] == 5'h1C |=>
		o_bit_hit && o_bit_rdata == $past(acc_bit)) else $error("accumulator bit read wrong");
endmodule : ccsr_core_regs_sva
bind ccsr_core_regs ccsr_core_regs_sva chk (.*);
`default_nettype wire

// [ccsr_core_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ccsr_core_regs_tb;
	logic i_core_clk = 1'h0, i_rst_b = 1'h0, i_acc_load = 1'h0, i_b_load = 1'h0, i_dptr_load = 1'h0;
	logic i_push = 1'h0, i_pop = 1'h0, o_sfr_hit, o_bit_rdata, o_bit_hit, o_stack_wr, o_stack_rd;
	logic [7:0] i_acc_value = 8'h00, i_b_value = 8'h00, o_sfr_rdata, o_psw, o_acc, o_b, o_sp, o_bank_base;
	logic [7:0] o_stack_addr;
	logic [15:0] i_dptr_value = 16'h0000, o_dptr;
	ccsr_pkg::ccsr_sfr_req_type i_sfr_req = '0;
	ccsr_pkg::ccsr_bit_req_type i_bit_req = '0;
	ccsr_pkg::ccsr_alu_flags_type i_alu_flags = '0;
	logic [7:0] ad [5] = '{ccsr_pkg::ADDR_SP, ccsr_pkg::ADDR_DPL, ccsr_pkg::ADDR_DPH, ccsr_pkg::ADDR_B,
		ccsr_pkg::ADDR_ACC};
	int num_errors = 0, tests_run = 0, cycles = 0;
	ccsr_core_regs dut (.*);
	always #5 i_core_clk = ~i_core_clk;
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Generous ceiling; the sequence needs well under two hundred cycles
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bw(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_sfr_req <= {a, 1'h1, 1'h0, d};
		@(posedge i_core_clk);
		i_sfr_req <= '0;
	endtask : bw
	task automatic br(input logic [7:0] a, input logic [7:0] e, input logic h);
		@(posedge i_core_clk);
		i_sfr_req <= {a, 1'h0, 1'h1, 8'h00};
		@(posedge i_core_clk);
		i_sfr_req <= '0;
		#1 chk({7'h00, o_sfr_hit, o_sfr_rdata}, {7'h00, h, e});
	endtask : br
	task automatic bt(input logic [7:0] a, input logic w, input logic d, input logic [1:0] e);
		@(posedge i_core_clk);
		i_bit_req <= {a, w, !w, d};
		@(posedge i_core_clk);
		i_bit_req <= '0;
		#1;
		if (!w) begin
			chk({14'h0000, o_bit_hit, o_bit_rdata}, {14'h0000, e});
		end
	endtask : bt
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_rst_b <= 1'h1;
		#1 chk({o_psw, o_acc}, 16'h0000);
		chk({o_b, o_sp}, 16'h0007);
		chk(o_dptr, 16'h0000);
		foreach (ad[i]) begin
			bw(ad[i], {4'hA, 4'(i)});
			br(ad[i], {4'hA, 4'(i)}, 1'h1);
		end
		chk(o_dptr, 16'hA2A1);
		chk({8'h00, o_psw}, 16'h0001);
		bw(ccsr_pkg::ADDR_ACC, 8'h03);
		bw(ccsr_pkg::ADDR_PSW, 8'hFF);
		br(ccsr_pkg::ADDR_PSW, 8'hFE, 1'h1);
		for (int r = 0; r < 4; r++) begin
			bw(ccsr_pkg::ADDR_PSW, {3'h0, 2'(r), 3'h0});
			#1 chk({8'h00, o_bank_base}, {8'h00, 3'h0, 2'(r), 3'h0});
		end
		bw(8'h84, 8'h55);
		br(8'h84, 8'h00, 1'h0);
		chk(o_dptr, 16'hA2A1);
		bt(8'hD5, 1'h1, 1'h1, 2'h0);
		bt(8'hD0, 1'h1, 1'h1, 2'h0);
		chk({8'h00, o_psw}, 16'h0038);
		bt(8'hE1, 1'h0, 1'h0, 2'h3);
		bt(8'hE2, 1'h0, 1'h0, 2'h2);
		bt(8'h81, 1'h0, 1'h0, 2'h0);
		@(posedge i_core_clk);
		i_alu_flags <= 3'h6;
		@(posedge i_core_clk);
		i_alu_flags <= 3'h5;
		@(posedge i_core_clk);
		i_alu_flags <= 3'h0;
		#1 chk({8'h00, o_psw}, 16'h0078);
		@(posedge i_core_clk);
		i_push <= 1'h1;
		repeat (2) @(posedge i_core_clk);
		i_push <= 1'h0;
		#1 chk({o_sp, o_stack_addr}, 16'hA2A2);
		chk({15'h0000, o_stack_wr}, 16'h0001);
		@(posedge i_core_clk);
		i_push <= 1'h1;
		i_pop <= 1'h1;
		@(posedge i_core_clk);
		i_push <= 1'h0;
		i_pop <= 1'h0;
		#1 chk({7'h00, o_stack_wr, o_sp}, 16'h00A2);
		@(posedge i_core_clk);
		i_pop <= 1'h1;
		@(posedge i_core_clk);
		i_pop <= 1'h0;
		#1 chk({o_stack_rd, o_stack_addr[6:0], o_sp}, 16'hA2A1);
		// Software write to the accumulator collides with a load; the load must win
		@(posedge i_core_clk);
		i_acc_load <= 1'h1;
		i_acc_value <= 8'h01;
		i_b_load <= 1'h1;
		i_b_value <= 8'h3C;
		i_dptr_load <= 1'h1;
		i_dptr_value <= 16'hBEEF;
		i_sfr_req <= {ccsr_pkg::ADDR_ACC, 1'h1, 1'h0, 8'hFF};
		@(posedge i_core_clk);
		i_acc_load <= 1'h0;
		i_b_load <= 1'h0;
		i_dptr_load <= 1'h0;
		i_sfr_req <= '0;
		#1 chk({o_acc, o_b}, 16'h013C);
		chk(o_dptr, 16'hBEEF);
		chk({8'h00, o_psw}, 16'h0079);
		@(posedge i_core_clk);
		i_rst_b <= 1'h0;
		@(posedge i_core_clk);
		i_rst_b <= 1'h1;
		#1 chk({o_b, o_sp}, 16'h0007);
		chk(o_dptr, 16'h0000);
		chk({8'h00, o_psw}, 16'h0000);
		br(ccsr_pkg::ADDR_SP, 8'h07, 1'h1);
		report_and_stop();
	end
endmodule : ccsr_core_regs_tb
`default_nettype wire

// [ccsr_pkg.sv]
package ccsr_pkg;
	// Byte addresses in the special-function space
	localparam logic [7:0] ADDR_SP = 8'h81;
	localparam logic [7:0] ADDR_DPL = 8'h82;
	localparam logic [7:0] ADDR_DPH = 8'h83;
	localparam logic [7:0] ADDR_PSW = 8'hD0;
	localparam logic [7:0] ADDR_ACC = 8'hE0;
	localparam logic [7:0] ADDR_B = 8'hF0;

	// Reset values
	localparam logic [7:0] RST_SP = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [6:0] RST_PSW_HI = 7'h00;
	localparam logic RST_PARITY = 1'b0;

	// Status word field positions
	localparam logic [2:0] PSW_CY = 3'h7;
	localparam logic [2:0] PSW_AC = 3'h6;
	localparam logic [2:0] PSW_F0 = 3'h5;
	localparam logic [2:0] PSW_RS1 = 3'h4;
	localparam logic [2:0] PSW_RS0 = 3'h3;
	localparam logic [2:0] PSW_OV = 3'h2;
	localparam logic [2:0] PSW_F1 = 3'h1;
	localparam logic [2:0] PSW_PARITY = 3'h0;

	// Bit-addressable registers sit at byte addresses whose low three bits are this
	localparam logic [2:0] BIT_BYTE_LOW = 3'h0;
	localparam logic [7:0] STACK_STEP = 8'h01;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} ccsr_sfr_req_type;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic wdata;
	} ccsr_bit_req_type;

	typedef struct packed {
		logic valid;
		logic carry;
		logic half_carry;
	} ccsr_alu_flags_type;
endpackage : ccsr_pkg

// [ccsr_sfr_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module ccsr_sfr_reg #(
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_byte_we,
	input wire logic [7:0] i_byte_data,
	input wire logic i_bit_we,
	input wire logic [2:0] i_bit_idx,
	input wire logic i_bit_data,
	input wire logic i_hw_we,
	input wire logic [7:0] i_hw_data,
	output logic [7:0] o_next,
	output logic [7:0] o_q
);
	// Datapath load wins over software so an instruction result is never lost
	always_comb begin
		o_next = o_q;
		if (i_hw_we) begin
			o_next = i_hw_data;
		end else if (i_byte_we) begin
			o_next = i_byte_data;
		end else if (i_bit_we) begin
			o_next[i_bit_idx] = i_bit_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_q <= RESET_VALUE;
		end else begin
			o_q <= o_next;
		end
	end
endmodule : ccsr_sfr_reg
`default_nettype wire
